// [design/token_seq.sv]
// Purpose: Transmit/receive sequencing of a token network controller
// Assumes: Link events come from protocol logic on sys_clk
// Notes:   Buffer contents stay outside; only page bases and headers
//
// Overview of operation
// - Byte 0 source id, byte 1 destination id
// - Short packet: byte 2 is 256 minus length
// - Long packet: byte 2 zero, byte 3 512-N
// - Long enabled: byte 2 zero means long
// - Own node id written into source byte
// - Enable transmit clears available and acked bits
// - Non-broadcast: free-buffer enquiry first on token
// - ACK then send; packet ACK sets both bits
// - NAK: pass token, enquire again next time
// - Answer enquiry with NAK while receiver inhibited
// - Excessive NAK flag, interrupt when enabled
// - Disable transmitter abandons at next token
// - No enquiry answer: available set, acked clear
// - Noise answer: token is not passed on
// - Interrupt on transmit conclusion if unmasked
// - Enable receive clears inhibit, selects page
// - Set receiver inhibited once packet stored
// - Chaining only while config bit 6 set
// - Chaining queues two tx, two rx, statuses
// - Chaining masks act on done event bits
// - Page base is nn*512 plus f*256
// - Only clear-transmit/receive-interrupt pops done events
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
module token_seq
   import token_seq_pkg::*;
#(
   parameter int NAK_LIMIT = NAK_LIMIT_DEF
) (
   // Clock, reset, enable
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Link events from protocol engine (one-cycle pulses)
   input  wire logic        token_in,
   input  wire logic        dest_is_bcast,
   input  wire logic        ack_in,
   input  wire logic        nak_in,
   input  wire logic        noise_in,
   input  wire logic        no_answer_in,
   input  wire logic        pkt_acked_in,
   input  wire logic        pkt_unanswered_in,
   input  wire logic        fbe_rx_in,
   input  wire logic        rx_done_in,
   // Header bytes of the packet being handled
   input  wire logic [7:0]  hdr_count,
   input  wire logic [7:0]  hdr_long_count,
   // Link requests (one-cycle pulses)
   output logic             send_fbe,
   output logic             send_pkt,
   output logic             pass_token,
   output logic             reply_ack,
   output logic             reply_nak,
   // Buffer addressing
   output logic             src_wr,
   output logic [10:0]      src_wr_addr,
   output logic [7:0]       src_wr_data,
   output logic [10:0]      tx_base,
   output logic [10:0]      rx_base,
   output logic             pkt_long,
   output logic [8:0]       info_len,
   output logic [8:0]       data_start,
   // Interrupt request
   output logic             irq
);
   if (NAK_LIMIT < 2 || NAK_LIMIT > 255) begin : g_chk
      $error("NAK_LIMIT must lie in 2..255");
   end
   localparam logic [7:0] NAK_LAST = 8'(NAK_LIMIT - 1);

   // ==========================================================
   // State
   typedef struct packed {
      tx_state_t   txs;
      logic        ta;
      logic        transmit_message_acked;
      logic        ri;
      logic [7:0]  mask;
      logic [7:0]  cfg;
      logic [7:0]  node;
      logic [1:0]  txv;
      logic [2:0]  txp0;
      logic [2:0]  txp1;
      logic [1:0]  cancel;
      logic [1:0]  rxv;
      logic [2:0]  rxp0;
      logic [2:0]  rxp1;
      logic [1:0]  tta_n;
      logic [1:0]  tta_ok;
      logic [1:0]  tri_n;
      logic [7:0]  nak_n;
      logic        excessive_nak_flag;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        send_fbe;
      logic        send_pkt;
      logic        pass_token;
      logic        reply_ack;
      logic        reply_nak;
      logic        src_wr;
      logic [10:0] src_wr_addr;
      logic [10:0] tx_base;
      logic [10:0] rx_base;
      logic        pkt_long;
      logic [8:0]  info_len;
      logic [8:0]  data_start;
      logic        irq;
   } state_t;

   state_t q;
   state_t d;

   // ==========================================================
   // Helpers
   function automatic logic [10:0] page_addr(input logic [2:0] fnn);
      page_addr = 11'(fnn[1:0] * PAGE_BYTES) + (fnn[2] ? HALF_BYTES : 11'h000);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == REG_STATUS) || (a == REG_MASK) || (a == REG_CMD) ||
               (a == REG_CONFIG) || (a == REG_NODE) || (a == REG_DIAG);
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      logic       chain;
      logic       wr;
      logic       rd_setup;
      logic [2:0] op;
      logic [2:0] fnn;
      logic       done;
      logic       done_ok;
      logic       tx_clr;
      logic       rx_clr;
      logic [1:0] n_after;
      logic       long_pkt;
      logic [7:0] st;
      d        = q;
      chain    = q.cfg[CFG_CHAIN];
      wr       = psel && penable && q.pready && pwrite;
      rd_setup = psel && !penable;
      op       = pwdata[2:0];
      fnn      = pwdata[CMD_OFS_BIT:CMD_PAGE_LO];
      done     = 1'b0;
      done_ok  = 1'b0;
      tx_clr   = 1'b0;
      rx_clr   = 1'b0;
      n_after  = 2'h0;
      long_pkt = 1'b0;
      st       = 8'h00;

      d.send_fbe   = 1'b0;
      d.send_pkt   = 1'b0;
      d.pass_token = 1'b0;
      d.reply_ack  = 1'b0;
      d.reply_nak  = 1'b0;
      d.src_wr     = 1'b0;

      // APB: zero wait states, ready rises in the access cycle
      d.pready  = rd_setup;
      d.pslverr = rd_setup && !mapped(paddr);

      // Register writes and commands
      if (wr && paddr == REG_MASK)
         d.mask = pwdata[7:0];
      if (wr && paddr == REG_CONFIG)
         d.cfg = pwdata[7:0];
      if (wr && paddr == REG_NODE)
         d.node = pwdata[7:0];
      if (wr && paddr == REG_DIAG)
         d.excessive_nak_flag = 1'b0;
      if (wr && paddr == REG_CMD) begin
         unique case (op)
            OP_EN_TX: begin
               d.ta    = 1'b0;
               d.transmit_message_acked   = 1'b0;
               d.nak_n = 8'h00;
               if (chain && q.txv[0]) begin
                  d.txv[1] = 1'b1;
                  d.txp1   = fnn;
               end else begin
                  d.txv[0] = 1'b1;
                  d.txp0   = fnn;
               end
            end
            OP_EN_RX: begin
               d.ri = 1'b0;
               if (chain && q.rxv[0]) begin
                  d.rxv[1] = 1'b1;
                  d.rxp1   = fnn;
               end else begin
                  d.rxv[0] = 1'b1;
                  d.rxp0   = fnn;
               end
            end
            OP_DIS_TX: begin
               // Acted on at the next token, oldest entry first
               if (q.cancel != 2'h2)
                  d.cancel = q.cancel + 2'h1;
            end
            OP_DIS_RX: begin
               d.rxv  = {1'b0, q.rxv[1]};
               d.rxp0 = q.rxp1;
               if (!q.rxv[1])
                  d.ri = 1'b1;
            end
            OP_CLR_TX: tx_clr = chain && q.tta_n != 2'h0;
            OP_CLR_RX: rx_clr = chain && q.tri_n != 2'h0;
            default: ;
         endcase
      end

      // Transmit sequencer
      unique case (q.txs)
         TX_IDLE: begin
            if (d.txv[0])
               d.txs = TX_TOK;
         end
         TX_TOK: begin
            if (token_in) begin
               if (q.cancel != 2'h0) begin
                  done         = 1'b1;
                  d.cancel     = q.cancel - 2'h1;
                  d.pass_token = 1'b1;
               end else if (dest_is_bcast) begin
                  d.send_pkt = 1'b1;
                  d.src_wr   = 1'b1;
                  d.txs      = TX_PKT;
               end else begin
                  d.send_fbe = 1'b1;
                  d.txs      = TX_FBE;
               end
            end
         end
         TX_FBE: begin
            if (ack_in) begin
               d.send_pkt = 1'b1;
               d.src_wr   = 1'b1;
               d.txs      = TX_PKT;
            end else if (nak_in) begin
               d.pass_token = 1'b1;
               d.txs        = TX_TOK;
               if (q.nak_n == NAK_LAST)
                  d.excessive_nak_flag = 1'b1;
               else
                  d.nak_n = q.nak_n + 8'h01;
            end else if (no_answer_in) begin
               done         = 1'b1;
               d.pass_token = 1'b1;
            end else if (noise_in) begin
               // Hold the token back; the ring reconfigures around us
               d.txs = TX_TOK;
            end
         end
         TX_PKT: begin
            if (pkt_acked_in || pkt_unanswered_in) begin
               done         = 1'b1;
               done_ok      = pkt_acked_in;
               d.pass_token = 1'b1;
            end
         end
         default: d.txs = TX_IDLE;
      endcase

      if (done) begin
         d.txv   = {1'b0, d.txv[1]};
         d.txp0  = d.txp1;
         d.nak_n = 8'h00;
         d.txs   = TX_IDLE;
         d.ta    = chain ? !d.txv[0] : 1'b1;
         d.transmit_message_acked   = done_ok;
      end

      // Done events in chaining mode; a clear applies before a completion in the same cycle
      n_after = q.tta_n - {1'b0, tx_clr};
      d.tta_ok = tx_clr ? {1'b0, q.tta_ok[1]} : q.tta_ok;
      if (done && chain && n_after != 2'h2) begin
         d.tta_ok[n_after[0]] = done_ok;
         n_after = n_after + 2'h1;
      end
      d.tta_n = n_after;

      // Receive side
      d.reply_nak = fbe_rx_in && q.ri;
      d.reply_ack = fbe_rx_in && !q.ri;
      n_after = q.tri_n - {1'b0, rx_clr};
      if (rx_done_in && q.rxv[0]) begin
         d.rxv  = {1'b0, d.rxv[1]};
         d.rxp0 = d.rxp1;
         d.ri   = chain ? !d.rxv[0] : 1'b1;
         if (chain && n_after != 2'h2)
            n_after = n_after + 2'h1;
      end
      d.tri_n = n_after;

      // Page bases and header decode
      d.tx_base     = page_addr(d.txp0);
      d.rx_base     = page_addr(d.rxp0);
      d.src_wr_addr = d.tx_base + SRC_OFS;
      long_pkt      = q.cfg[CFG_LONG] && hdr_count == 8'h00;
      d.pkt_long    = long_pkt;
      d.info_len    = long_pkt ? 9'(LONG_SPAN - {2'b00, hdr_long_count})
                               : SHORT_SPAN - {1'b0, hdr_count};
      d.data_start  = long_pkt ? {1'b0, hdr_long_count} : {1'b0, hdr_count};

      // Interrupt: done events in chaining, levels otherwise; the excessive NAK flag is a level in both
      if (d.cfg[CFG_CHAIN])
         d.irq = (d.mask[MSK_TA] && d.tta_n != 2'h0) ||
                 (d.mask[MSK_RI] && d.tri_n != 2'h0);
      else
         d.irq = (d.mask[MSK_TA] && d.ta) ||
                 (d.mask[MSK_RI] && d.ri);
      d.irq = d.irq || (d.mask[MSK_EXC] && d.excessive_nak_flag);

      // Read data captured in the setup cycle
      st[ST_TA]     = q.ta;
      st[ST_TMA]    = chain ? q.tta_ok[0] : q.transmit_message_acked;
      st[ST_TTA]    = q.tta_n != 2'h0;
      st[ST_TRI]    = q.tri_n != 2'h0;
      st[ST_EXCESSIVE_NAK_FLAG] = q.excessive_nak_flag;
      st[ST_RI]     = q.ri;
      d.prdata = 32'h0000_0000;
      if (rd_setup && !pwrite) begin
         unique case (paddr)
            REG_STATUS: d.prdata = {24'h00_0000, st};
            REG_MASK:   d.prdata = {24'h00_0000, q.mask};
            REG_CONFIG: d.prdata = {24'h00_0000, q.cfg};
            REG_NODE:   d.prdata = {24'h00_0000, q.node};
            REG_DIAG:   d.prdata = {27'h000_0000, q.excessive_nak_flag, 4'h0};
            default:    d.prdata = 32'h0000_0000;
         endcase
      end

      if (!rst_b) begin
         d      = '0;
         d.txs  = TX_IDLE;
         d.ta   = TA_RST;
         d.ri   = RI_RST;
         d.cfg  = CFG_RST;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b || ce)
         q <= d;
   end

   // ==========================================================
   // Outputs straight from the state register
   assign pready      = q.pready;
   assign prdata      = q.prdata;
   assign pslverr     = q.pslverr;
   assign send_fbe    = q.send_fbe;
   assign send_pkt    = q.send_pkt;
   assign pass_token  = q.pass_token;
   assign reply_ack   = q.reply_ack;
   assign reply_nak   = q.reply_nak;
   assign src_wr      = q.src_wr;
   assign src_wr_addr = q.src_wr_addr;
   assign src_wr_data = q.node;
   assign tx_base     = q.tx_base;
   assign rx_base     = q.rx_base;
   assign pkt_long    = q.pkt_long;
   assign info_len    = q.info_len;
   assign data_start  = q.data_start;
   assign irq         = q.irq;
endmodule

// [shared/token_seq_pkg.sv]
// Purpose: Shared constants for the token network packet sequencer
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Commands use op in bits 2:0, page select f,nn in bits 5:3
package token_seq_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_MASK   = 8'h04;
   localparam logic [7:0] REG_CMD    = 8'h08;
   localparam logic [7:0] REG_CONFIG = 8'h0C;
   localparam logic [7:0] REG_NODE   = 8'h10;
   localparam logic [7:0] REG_DIAG   = 8'h14;
   // ==========================================================
   // Status, mask, command and config bit positions
   localparam int ST_TA     = 0;
   localparam int ST_TMA    = 1;
   localparam int ST_TTA    = 2;
   localparam int ST_TRI    = 3;
   localparam int ST_EXCESSIVE_NAK_FLAG = 4;
   localparam int ST_RI     = 7;
   localparam int MSK_TA    = 0;
   localparam int MSK_EXC   = 2;
   localparam int MSK_RI    = 7;
   localparam int CFG_LONG  = 3;
   localparam int CFG_CHAIN = 6;
   localparam int CMD_PAGE_LO = 3;
   localparam int CMD_OFS_BIT = 5;
   // ==========================================================
   // Command op codes (bits 2:0 of a command write)
   localparam logic [2:0] OP_DIS_TX = 3'h1;
   localparam logic [2:0] OP_DIS_RX = 3'h2;
   localparam logic [2:0] OP_EN_TX  = 3'h3;
   localparam logic [2:0] OP_EN_RX  = 3'h4;
   localparam logic [2:0] OP_CLR_TX = 3'h5;
   localparam logic [2:0] OP_CLR_RX = 3'h6;
   // ==========================================================
   // Page buffer layout
   localparam logic [10:0] SRC_OFS    = 11'h000;
   localparam logic [10:0] DST_OFS    = 11'h001;
   localparam logic [10:0] CNT_OFS    = 11'h002;
   localparam logic [10:0] LCNT_OFS   = 11'h003;
   localparam logic [10:0] PAGE_BYTES = 11'h200;
   localparam logic [10:0] HALF_BYTES = 11'h100;
   localparam logic [8:0]  SHORT_SPAN = 9'h100;
   localparam logic [9:0]  LONG_SPAN  = 10'h200;
   // ==========================================================
   // Reset values and counts
   localparam logic       TA_RST    = 1'b1;
   localparam logic       RI_RST    = 1'b1;
   localparam logic [7:0] CFG_RST   = 8'h00;
   localparam int         NAK_LIMIT_DEF = 128;
   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_TOK  = 4'b0010,
      TX_FBE  = 4'b0100,
      TX_PKT  = 4'b1000
   } tx_state_t;
endpackage

// [tb/link_peer_model.sv]
// Purpose: Peer nodes answering enquiries and packets
// Assumes: One request outstanding at a time
// Notes:   Answer kind and delay chosen by the bench
`timescale 1ns/10ps
module link_peer_model (
   // Clock
   input wire logic       sys_clk,
   // Bench control
   input wire logic [2:0] mode,
   input wire logic [1:0] dly,
   // Requests
   input wire logic       send_fbe,
   input wire logic       send_pkt,
   // Answers
   output logic           ack_in,
   output logic           nak_in,
   output logic           noise_in,
   output logic           no_answer_in,
   output logic           pkt_acked_in,
   output logic           pkt_unanswered_in
);
   logic       req, go, p, pk_q;
   logic [1:0] wt_q;
   initial begin
      {ack_in, nak_in, noise_in, no_answer_in, pkt_acked_in, pkt_unanswered_in} = 6'h00;
      pk_q = 1'b0;
      wt_q = 2'h0;
   end
   // Slow answers keep the sequencer waiting in its answer state
   always @(posedge sys_clk) begin
      req = send_fbe | send_pkt;
      go = req ? (dly == 2'h0) : (wt_q == 2'h1);
      p = req ? send_pkt : pk_q;
      pk_q <= p;
      wt_q <= req ? dly : (wt_q != 2'h0 ? wt_q - 2'h1 : 2'h0);
      ack_in <= go & !p & (mode == 3'h0 || mode == 3'h4);
      nak_in <= go & !p & (mode == 3'h1);
      noise_in <= go & !p & (mode == 3'h2);
      no_answer_in <= go & !p & (mode == 3'h3);
      pkt_acked_in <= go & p & (mode == 3'h0);
      pkt_unanswered_in <= go & p & (mode == 3'h4);
   end
endmodule

// [tb/test_token_seq.sv]
// Purpose: Self-checking bench for token_seq
// Assumes: Zero-wait APB, NAK_LIMIT set to 3
// Notes:   Random pages, ids, delays and headers
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module test_token_seq
   import token_seq_pkg::*;
();
   logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, serr, lng, passed;
   logic token_in = 0, dest_is_bcast = 0, fbe_rx_in = 0, rx_done_in = 0;
   logic [7:0]  paddr = 8'h00, hdr_count = 8'h01, hdr_long_count = 8'h01, node;
   logic [31:0] pwdata = 32'h0, rdat;
   logic [2:0]  mode = 3'h0, pg;
   logic [1:0]  dly = 2'h0;
   logic [10:0] expb = 11'h000;
   wire  pready, pslverr, send_fbe, send_pkt, pass_token, reply_ack, reply_nak, src_wr;
   wire  pkt_long, irq, ack_in, nak_in, noise_in, no_answer_in, pkt_acked_in;
   wire  pkt_unanswered_in;
   wire  [31:0] prdata;
   wire  [10:0] src_wr_addr, tx_base, rx_base;
   wire  [7:0]  src_wr_data;
   wire  [8:0]  info_len, data_start;
   int   fail_count = 0, checks_done = 0, cyc = 0, seed = 55087, i, k;

   token_seq #(.NAK_LIMIT(3)) u_dut (.sys_clk, .rst_b, .ce(1'b1), .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .token_in, .dest_is_bcast,
      .ack_in, .nak_in, .noise_in, .no_answer_in, .pkt_acked_in, .pkt_unanswered_in,
      .fbe_rx_in, .rx_done_in, .hdr_count, .hdr_long_count, .send_fbe, .send_pkt,
      .pass_token, .reply_ack, .reply_nak, .src_wr, .src_wr_addr, .src_wr_data, .tx_base,
      .rx_base, .pkt_long, .info_len, .data_start, .irq);
   link_peer_model u_peer (.sys_clk, .mode, .dly, .send_fbe, .send_pkt, .ack_in, .nak_in,
      .noise_in, .no_answer_in, .pkt_acked_in, .pkt_unanswered_in);

   always #20 sys_clk = ~sys_clk;
   // ==========================================================
   // Expectations
   function automatic logic [10:0] base(input logic [2:0] g);
      return 11'(g[1:0]) * 11'h200 + 11'(g[2]) * 11'h100;
   endfunction
   function automatic logic [7:0] tx_st(input int m);
      return (m == 0) ? 8'h03 : (m > 2) ? 8'h01 : 8'h00;
   endfunction
   function automatic logic [8:0] ilen(input logic l);
      return l ? 9'(10'h200 - {2'b00, hdr_long_count}) : 9'(9'h100 - {1'b0, hdr_count});
   endfunction
   // ==========================================================
   // Drivers
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rdat = prdata;
      serr = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task st(input logic [7:0] m, input logic [7:0] e);
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK("status", e, rdat[7:0] & m)
   endtask
   task pulse(input int w);
      @(posedge sys_clk);
      {token_in, fbe_rx_in, rx_done_in} <= 3'(3'h4 >> w);
      @(posedge sys_clk);
      {token_in, fbe_rx_in, rx_done_in} <= 3'h0;
   endtask
   task tx(input logic [2:0] m, input logic [1:0] d);
      mode <= m;
      dly <= d;
      pulse(0);
      passed = 1'b0;
      for (k = 0; k < 24 && !passed; k++) begin
         @(posedge sys_clk);
         passed = pass_token;
      end
   endtask
   task complete_run;
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ==========================================================
   // Monitors and timeout
   always @(posedge sys_clk) begin
      if (src_wr === 1'b1) begin
         `CHK("own id", node, src_wr_data)
         `CHK("tx base", expb, tx_base)
      end
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   // ==========================================================
   // Scenarios
   initial begin
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      st(8'hFF, 8'h81);
      apb(1'b0, REG_CONFIG, 32'h0);
      `CHK("config", 32'h0, rdat)
      apb(1'b0, 8'h3C, 32'h0);
      `CHK("unmapped", 1'b1, serr)
      node = 8'($random(seed)) | 8'h01;
      apb(1'b1, REG_MASK, 32'h05);
      apb(1'b1, REG_NODE, {24'h0, node});
      // Every answer kind, then a broadcast
      for (i = 0; i < 6; i++) begin
         pg = 3'($random(seed));
         apb(1'b1, REG_CMD, {26'h0, pg, OP_EN_TX});
         expb = base(pg);
         st(8'h03, 8'h00);
         `CHK("tx irq idle", 1'b0, irq)
         dest_is_bcast <= (i == 5);
         tx(3'(i % 5), 2'($random(seed)));
         if (i == 1 || i == 2) `CHK("pass", i == 1, passed)
         st(8'h03, tx_st(i % 5));
         if (i == 1 || i == 2) tx(3'h0, 2'h0);
         st(8'h03, (i == 1 || i == 2) ? 8'h03 : tx_st(i % 5));
         `CHK("tx irq", 1'b1, irq)
      end
      $display("transmit outcomes done");
      dest_is_bcast <= 1'b0;
      apb(1'b1, REG_CMD, {26'h0, pg, OP_EN_TX});
      for (i = 0; i < 3; i++) tx(3'h1, 2'h0);
      apb(1'b0, REG_DIAG, 32'h0);
      `CHK("excessive_nak_flag", 1'b1, rdat[ST_EXCESSIVE_NAK_FLAG])
      `CHK("excessive_nak_flag irq", 1'b1, irq)
      apb(1'b1, REG_DIAG, 32'h0);
      apb(1'b0, REG_DIAG, 32'h0);
      `CHK("excessive_nak_flag clear", 1'b0, rdat[ST_EXCESSIVE_NAK_FLAG])
      apb(1'b1, REG_CMD, {29'h0, OP_DIS_TX});
      tx(3'h0, 2'h0);
      `CHK("abandon", 1'b1, passed)
      st(8'h03, 8'h01);
      $display("abandon done");
      pulse(1);
      @(posedge sys_clk);
      `CHK("nak reply", 1'b1, reply_nak)
      pg = 3'($random(seed));
      apb(1'b1, REG_CMD, {26'h0, pg, OP_EN_RX});
      st(8'h80, 8'h00);
      `CHK("rx base", base(pg), rx_base)
      pulse(1);
      @(posedge sys_clk);
      `CHK("ack reply", 1'b1, reply_ack)
      apb(1'b1, REG_MASK, 32'h80);
      pulse(2);
      st(8'h80, 8'h80);
      `CHK("rx irq", 1'b1, irq)
      $display("receive done");
      for (i = 0; i < 24; i++) begin
         if (i == 12) apb(1'b1, REG_CONFIG, 32'h08);
         @(posedge sys_clk);
         hdr_count <= (i % 4 == 0) ? 8'h00 : 8'h03 + 8'($unsigned($random(seed)) % 253);
         hdr_long_count <= 8'h01 + 8'($unsigned($random(seed)) % 255);
         repeat (2) @(posedge sys_clk);
         lng = i > 11 && hdr_count == 8'h00;
         `CHK("long", lng, pkt_long)
         `CHK("len", ilen(lng), info_len)
         `CHK("start", lng ? {1'b0, hdr_long_count} : {1'b0, hdr_count}, data_start)
      end
      $display("header decode done");
      apb(1'b1, REG_CONFIG, 32'h40);
      apb(1'b1, REG_MASK, 32'h01);
      for (i = 0; i < 2; i++) apb(1'b1, REG_CMD, {26'h0, 3'(i), OP_EN_TX});
      for (i = 0; i < 2; i++) begin
         expb = base(3'(i));
         tx(3'h0, 2'h0);
      end
      st(8'h06, 8'h06);
      `CHK("chain irq", 1'b1, irq)
      apb(1'b1, REG_CMD, {29'h0, OP_CLR_TX});
      st(8'h06, 8'h06);
      apb(1'b1, REG_CMD, {29'h0, OP_CLR_TX});
      st(8'h06, 8'h00);
      `CHK("chain irq off", 1'b0, irq)
      $display("chaining done");
      complete_run();
   end
endmodule

// [tb/token_seq_asserts.sv]
// Purpose: Port-level checks for token_seq
// Assumes: ce held high by the bench
// Notes:   Bound into every token_seq instance
`timescale 1ns/10ps
module token_seq_asserts (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rst_b,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   // Link
   input wire logic        token_in,
   input wire logic        dest_is_bcast,
   input wire logic        ack_in,
   input wire logic        nak_in,
   input wire logic        noise_in,
   input wire logic        fbe_rx_in,
   input wire logic        send_fbe,
   input wire logic        send_pkt,
   input wire logic        pass_token,
   input wire logic        reply_ack,
   input wire logic        reply_nak,
   // Buffer
   input wire logic [7:0]  hdr_count,
   input wire logic [7:0]  hdr_long_count,
   input wire logic        src_wr,
   input wire logic [10:0] src_wr_addr,
   input wire logic [10:0] tx_base,
   input wire logic        pkt_long,
   input wire logic [8:0]  info_len
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // APB
   chk_apb_zero_wait: assert property (psel && !penable |=> pready)
      else $error("pready missing in access");
   chk_ready_phase: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // ==========================================================
   // Transmit and receive link
   chk_enquiry_cause: assert property (
      send_fbe |-> $past(token_in) && !$past(dest_is_bcast)) else $error("stray enquiry");
   chk_packet_cause: assert property (
      send_pkt |-> $past(ack_in) || ($past(token_in) && $past(dest_is_bcast)))
      else $error("packet sent without ack");
   chk_own_id: assert property (send_pkt |-> src_wr && src_wr_addr == tx_base)
      else $error("own id not written");
   chk_enq_reply: assert property (fbe_rx_in |=> reply_ack != reply_nak)
      else $error("enquiry reply wrong");
   chk_nak_passes: assert property (
      nak_in && $past(send_fbe) |=> pass_token ##1 !pass_token) else $error("nak no pass");
   chk_noise_holds: assert property (
      noise_in |=> !pass_token [*4]) else $error("token passed on noise");
   // ==========================================================
   // Header decode, one cycle behind the inputs
   chk_short_len: assert property ($past(rst_b) && !pkt_long
      |-> info_len == 9'h100 - $past(hdr_count)) else $error("short length wrong");
   chk_long_len: assert property ($past(rst_b) && pkt_long |-> $past(hdr_count) == 8'h00
      && info_len == 10'h200 - $past(hdr_long_count)) else $error("long length wrong");
endmodule

bind token_seq token_seq_asserts u_chk (.sys_clk, .rst_b, .psel, .penable, .pready,
   .pslverr, .token_in, .dest_is_bcast, .ack_in, .nak_in, .noise_in, .fbe_rx_in,
   .send_fbe, .send_pkt, .pass_token, .reply_ack, .reply_nak, .hdr_count,
   .hdr_long_count, .src_wr, .src_wr_addr, .tx_base, .pkt_long, .info_len);
